// >>> pkg/itc_cfg.svh
// Named constants of the input terminal conditioner: timing, reset values, indices and codes.
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH

// One count of the filter and delay settings is one millisecond.
`define ITC_CLK_NS        40
`define ITC_TICK_NS       1000000
`define ITC_TICK_CYCLES   (`ITC_TICK_NS / `ITC_CLK_NS)

`define ITC_FILT_MAX      16'h03E8
`define ITC_DLY_MAX       16'hC350
`define ITC_FILT_RST      16'h000A
`define ITC_DLY_RST       16'h0000
`define ITC_POL_RST       9'h000
`define ITC_VEN_RST       9'h000
`define ITC_VTS_RST       16'h0000
`define ITC_MODE_RST      2'h0
`define ITC_FAST_TYPE_RST 1'h0
`define ITC_FSEL1_RST     7'h01
`define ITC_FSEL2_RST     7'h04
`define ITC_FSEL3_RST     7'h07
`define ITC_FSEL_RST      7'h00
`define ITC_FSEL_MAX      7'h5F

// Register indices; the byte address is four times the index.
`define ITC_IDX_VTS       14'h200A
`define ITC_IDX_POL       14'h2010
`define ITC_IDX_FILT      14'h2011
`define ITC_IDX_VEN       14'h2012
`define ITC_IDX_MODE      14'h2013
`define ITC_IDX_FAST_TYPE 14'h2014
`define ITC_IDX_DLY_BASE  14'h2015
`define ITC_IDX_FSEL_BASE 14'h2020
`define ITC_IDX_STATUS    14'h2030
`define ITC_IDX_CMD       14'h2031

// Terminal function codes.
`define ITC_FN_RUN_FWD    7'h01
`define ITC_FN_RUN_REV    7'h02
`define ITC_FN_THREE_WIRE 7'h03
`define ITC_FN_JOG_FWD    7'h04
`define ITC_FN_CH_KEYPAD  7'h24
`define ITC_FN_CH_TERM    7'h25
`define ITC_FN_CH_COMM    7'h26
`define ITC_FN_PRE_EXCITE 7'h27
`define ITC_FN_E_CLEAR    7'h28
`define ITC_FN_E_HOLD     7'h29
`define ITC_FN_BRAKE_KPAD 7'h2A
`define ITC_FN_REG_INVERT 7'h3D

`endif

// >>> pkg/itc_pkg.sv
// Types shared by the input terminal conditioner modules.
package itc_pkg;

    typedef logic [8:0] term_vec_t;
    typedef logic [6:0] fsel_t;

    typedef enum logic [1:0] {
        MODE_TWO_WIRE_1,
        MODE_TWO_WIRE_2,
        MODE_THREE_WIRE_1,
        MODE_THREE_WIRE_2
    } ctrl_mode_e;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_e;

    typedef struct packed {
        term_vec_t         pol;
        logic [15:0]       filt;
        term_vec_t         ven;
        ctrl_mode_e        mode;
        logic              fast_type;
        logic [3:0][15:0]  on_dly;
        logic [3:0][15:0]  off_dly;
        logic [15:0]       vts;
        logic [8:0][6:0]   fsel;
    } cfg_s;

    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic three_wire;
        logic jog_fwd;
        logic chan_keypad;
        logic chan_terminal;
        logic chan_comm;
        logic pre_excite;
        logic energy_clear;
        logic energy_hold;
        logic brake_lim_keypad;
        logic regulator_invert;
    } cmd_s;

    typedef struct packed {
        logic        wr;
        logic [13:0] idx;
        logic [31:0] wdata;
        logic [3:0]  be;
    } bus_req_s;

endpackage

// >>> core/stable_timer.sv
// Level follower that passes a change only after it has stood for a number of ticks.
`timescale 1ns/10ps
`default_nettype none

module stable_timer #(
    parameter int CW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic          level_in,
    input  wire logic [CW-1:0] on_limit,
    input  wire logic [CW-1:0] off_limit,
    output logic               level_out
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] limit;
    logic          out_q;
    logic          out_d;

    if (CW < 1) begin : g_bad_cw
        $error("CW below 1");
    end

    // A bounce back to the old level restarts the count, so short glitches never pass.
    always_comb begin
        limit = level_in ? on_limit : off_limit;
        cnt_d = cnt_q;
        out_d = out_q;
        if (level_in == out_q) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            out_d = level_in;
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign level_out = out_q;

endmodule // stable_timer

`default_nettype wire

// >>> core/avalon_reg_port.sv
// Avalon-MM slave handshake: one wait cycle, then a single-cycle answer.
`timescale 1ns/10ps
`default_nettype none

module avalon_reg_port
    import itc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [31:0] rd_word,
    output bus_req_s         req
);

    bus_state_e  state_q;
    bus_state_e  state_d;
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Read data is captured when the request is first seen and stands through the answer cycle.
    always_comb begin
        state_d = BUS_IDLE;
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        case (state_q)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_d = BUS_ACK;
                    wait_d  = 1'b0;
                    if (avs_read) begin
                        rdata_d = rd_word;
                    end
                end
            end
            BUS_ACK: begin
                state_d = BUS_IDLE;
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // The write commits at the same edge at which the master sees waitrequest low.
    assign req.wr          = (state_q == BUS_ACK) && avs_write;
    assign req.idx         = avs_address[15:2];
    assign req.wdata       = avs_writedata;
    assign req.be          = avs_byteenable;
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

endmodule // avalon_reg_port

`default_nettype wire

// >>> core/input_terminal_conditioner.sv
// Input terminal conditioner: polarity, filtering, delays, virtual override and function decode.
//
// What this block does
// - Nine-bit polarity mask; a set bit inverts that terminal to active-low.
// - One sampling filter time, 0 to 1 s, default 10 ms, for all nine.
// - Virtual-enable mask; bits 0-7 switch inputs, bit 8 fast input; 1 means virtual.
// - A virtual terminal ignores its pin and follows only communication writes.
// - The virtual terminal state word sits at one fixed communication address.
// - Two-bit terminal control mode selects two-wire 1/2 or three-wire 1/2.
// - Switch inputs one to four delay going active by their own on-delay.
// - Switch inputs one to four delay going inactive by a separate off-delay.
// - Codes 36, 37, 38 move the run command channel to keypad, terminal, comm.
// - Code 39 pre-excites; 40 clears and 41 holds the energy accumulator.
// - Code 42 selects keypad braking-torque limit; 61 inverts the regulator; reserved do nothing.
// - Fast input is a pulse input at type 0 and a digital input at type 1.
// - Each input has a function code 0-95; 1 fwd, 2 rev, 3 three-wire, 4 jog.
//
// Chosen here: the Avalon-MM interface to the registers.
`include "itc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module input_terminal_conditioner
    import itc_pkg::*;
#(
    parameter int TICK_CYCLES = `ITC_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        switch_input_one,
    input  wire logic        switch_input_two,
    input  wire logic        switch_input_three,
    input  wire logic        switch_input_four,
    input  wire logic        switch_input_five,
    input  wire logic        switch_input_six,
    input  wire logic        switch_input_seven,
    input  wire logic        switch_input_eight,
    input  wire logic        fast_pulse_input,
    output term_vec_t        terminal_state,
    output cmd_s             terminal_commands,
    output ctrl_mode_e       terminal_control_mode,
    output logic             fast_pulse_level
);

    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Filter and delay settings above their range saturate rather than wrap.
    function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] max);
        return (v > max) ? max : v;
    endfunction

    // True when any active terminal carries the given function code.
    function automatic logic any_code(input logic [8:0][6:0] sel,
                                      input term_vec_t       act,
                                      input fsel_t           code);
        logic hit;
        hit = 1'b0;
        for (int t = 0; t < 9; t++) begin
            hit = hit | (act[t] && sel[t] == code);
        end
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    bus_req_s    bus;
    logic [31:0] rd_word;
    cfg_s        cfg_q;
    cfg_s        cfg_d;
    logic [31:0] merged;
    term_vec_t   term_q;
    term_vec_t   term_d;
    cmd_s        cmd_q;
    cmd_s        cmd_d;
    term_vec_t   pins;

    avalon_reg_port u_port (
        .clk             (clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rd_word         (rd_word),
        .req             (bus)
    );

    // Reads of unmapped indices return zero; reserved bits read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (bus.idx)
            `ITC_IDX_VTS:       rd_word[15:0] = cfg_q.vts;
            `ITC_IDX_POL:       rd_word[8:0]  = cfg_q.pol;
            `ITC_IDX_FILT:      rd_word[15:0] = cfg_q.filt;
            `ITC_IDX_VEN:       rd_word[8:0]  = cfg_q.ven;
            `ITC_IDX_MODE:      rd_word[1:0]  = cfg_q.mode;
            `ITC_IDX_FAST_TYPE: rd_word[0]    = cfg_q.fast_type;
            `ITC_IDX_STATUS:    rd_word[24:0] = {pins, 7'h00, term_q};
            `ITC_IDX_CMD:       rd_word[11:0] = cmd_q;
            default: begin
                for (int k = 0; k < 4; k++) begin
                    if (bus.idx == `ITC_IDX_DLY_BASE + 14'(2 * k)) begin
                        rd_word[15:0] = cfg_q.on_dly[k];
                    end
                    if (bus.idx == `ITC_IDX_DLY_BASE + 14'(2 * k + 1)) begin
                        rd_word[15:0] = cfg_q.off_dly[k];
                    end
                end
                for (int t = 0; t < 9; t++) begin
                    if (bus.idx == `ITC_IDX_FSEL_BASE + 14'(t)) begin
                        rd_word[6:0] = cfg_q.fsel[t];
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_comb begin
        cfg_d  = cfg_q;
        merged = 32'h0000_0000;
        if (bus.wr) begin
            case (bus.idx)
                `ITC_IDX_VTS: begin
                    merged    = be_merge({16'h0000, cfg_q.vts}, bus.wdata, bus.be);
                    cfg_d.vts = merged[15:0];
                end
                `ITC_IDX_POL: begin
                    merged    = be_merge({23'h0, cfg_q.pol}, bus.wdata, bus.be);
                    cfg_d.pol = merged[8:0];
                end
                `ITC_IDX_FILT: begin
                    merged     = be_merge({16'h0000, cfg_q.filt}, bus.wdata, bus.be);
                    cfg_d.filt = sat16(merged[15:0], `ITC_FILT_MAX);
                end
                `ITC_IDX_VEN: begin
                    merged    = be_merge({23'h0, cfg_q.ven}, bus.wdata, bus.be);
                    cfg_d.ven = merged[8:0];
                end
                `ITC_IDX_MODE: begin
                    merged     = be_merge({30'h0, cfg_q.mode}, bus.wdata, bus.be);
                    cfg_d.mode = ctrl_mode_e'(merged[1:0]);
                end
                `ITC_IDX_FAST_TYPE: begin
                    merged          = be_merge({31'h0, cfg_q.fast_type}, bus.wdata, bus.be);
                    cfg_d.fast_type = merged[0];
                end
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (bus.idx == `ITC_IDX_DLY_BASE + 14'(2 * k)) begin
                            merged = be_merge({16'h0000, cfg_q.on_dly[k]}, bus.wdata, bus.be);
                            cfg_d.on_dly[k] = sat16(merged[15:0], `ITC_DLY_MAX);
                        end
                        if (bus.idx == `ITC_IDX_DLY_BASE + 14'(2 * k + 1)) begin
                            merged = be_merge({16'h0000, cfg_q.off_dly[k]}, bus.wdata, bus.be);
                            cfg_d.off_dly[k] = sat16(merged[15:0], `ITC_DLY_MAX);
                        end
                    end
                    for (int t = 0; t < 9; t++) begin
                        if (bus.idx == `ITC_IDX_FSEL_BASE + 14'(t)) begin
                            merged = be_merge({25'h0, cfg_q.fsel[t]}, bus.wdata, bus.be);
                            // Codes above the range are refused; the old code stays.
                            if (merged[6:0] <= `ITC_FSEL_MAX) begin
                                cfg_d.fsel[t] = merged[6:0];
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q.vts       <= `ITC_VTS_RST;
            cfg_q.pol       <= `ITC_POL_RST;
            cfg_q.filt      <= `ITC_FILT_RST;
            cfg_q.ven       <= `ITC_VEN_RST;
            cfg_q.mode      <= ctrl_mode_e'(`ITC_MODE_RST);
            cfg_q.fast_type <= `ITC_FAST_TYPE_RST;
            cfg_q.on_dly    <= {4{`ITC_DLY_RST}};
            cfg_q.off_dly   <= {4{`ITC_DLY_RST}};
            cfg_q.fsel      <= {{6{`ITC_FSEL_RST}}, `ITC_FSEL3_RST,
                                `ITC_FSEL2_RST, `ITC_FSEL1_RST};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    logic [15:0] tick_cnt_q;
    logic [15:0] tick_cnt_d;
    logic        tick_q;
    logic        tick_d;

    always_comb begin
        tick_d     = (tick_cnt_q == 16'(TICK_CYCLES - 1));
        tick_cnt_d = tick_d ? 16'h0000 : tick_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Physical terminal path

    term_vec_t pol_in;
    term_vec_t filt_out;
    logic [3:0] dly_out;
    term_vec_t proc_lvl;

    assign pins   = {fast_pulse_input, switch_input_eight, switch_input_seven,
                     switch_input_six, switch_input_five, switch_input_four,
                     switch_input_three, switch_input_two, switch_input_one};
    assign pol_in = pins ^ cfg_q.pol;

    for (genvar i = 0; i < 9; i++) begin : g_filt
        stable_timer #(.CW(16)) u_filt (
            .clk       (clk),
            .rst       (rst),
            .tick      (tick_q),
            .level_in  (pol_in[i]),
            .on_limit  (cfg_q.filt),
            .off_limit (cfg_q.filt),
            .level_out (filt_out[i])
        );
    end

    for (genvar i = 0; i < 4; i++) begin : g_dly
        stable_timer #(.CW(16)) u_dly (
            .clk       (clk),
            .rst       (rst),
            .tick      (tick_q),
            .level_in  (filt_out[i]),
            .on_limit  (cfg_q.on_dly[i]),
            .off_limit (cfg_q.off_dly[i]),
            .level_out (dly_out[i])
        );
    end

    // In pulse mode the fast input carries no digital level of its own.
    always_comb begin
        proc_lvl    = {filt_out[8:4], dly_out};
        proc_lvl[8] = cfg_q.fast_type & filt_out[8];
        term_d = (cfg_q.ven & cfg_q.vts[8:0]) | (~cfg_q.ven & proc_lvl);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Function decode

    // Reserved and unlisted codes match nothing below and so cause no action.
    always_comb begin
        cmd_d                  = '0;
        cmd_d.run_fwd          = any_code(cfg_q.fsel, term_q, `ITC_FN_RUN_FWD);
        cmd_d.run_rev          = any_code(cfg_q.fsel, term_q, `ITC_FN_RUN_REV);
        cmd_d.three_wire       = any_code(cfg_q.fsel, term_q, `ITC_FN_THREE_WIRE);
        cmd_d.jog_fwd          = any_code(cfg_q.fsel, term_q, `ITC_FN_JOG_FWD);
        cmd_d.chan_keypad      = any_code(cfg_q.fsel, term_q, `ITC_FN_CH_KEYPAD);
        cmd_d.chan_terminal    = any_code(cfg_q.fsel, term_q, `ITC_FN_CH_TERM);
        cmd_d.chan_comm        = any_code(cfg_q.fsel, term_q, `ITC_FN_CH_COMM);
        cmd_d.pre_excite       = any_code(cfg_q.fsel, term_q, `ITC_FN_PRE_EXCITE);
        cmd_d.energy_clear     = any_code(cfg_q.fsel, term_q, `ITC_FN_E_CLEAR);
        cmd_d.energy_hold      = any_code(cfg_q.fsel, term_q, `ITC_FN_E_HOLD);
        cmd_d.brake_lim_keypad = any_code(cfg_q.fsel, term_q, `ITC_FN_BRAKE_KPAD);
        cmd_d.regulator_invert = any_code(cfg_q.fsel, term_q, `ITC_FN_REG_INVERT);
    end

    logic fast_lvl_q;
    logic fast_lvl_d;

    // The raw fast pin goes to the frequency measurement only in pulse mode.
    assign fast_lvl_d = ~cfg_q.fast_type & fast_pulse_input;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term_q     <= '0;
            cmd_q      <= '0;
            fast_lvl_q <= 1'b0;
        end else begin
            term_q     <= term_d;
            cmd_q      <= cmd_d;
            fast_lvl_q <= fast_lvl_d;
        end
    end

    assign terminal_state        = term_q;
    assign terminal_commands     = cmd_q;
    assign terminal_control_mode = cfg_q.mode;
    assign fast_pulse_level      = fast_lvl_q;

endmodule // input_terminal_conditioner

`default_nettype wire

// >>> tb/field_contacts.sv
// Field contact model that feeds the nine terminal pins.
`timescale 1ns/10ps
`default_nettype none
module field_contacts (
    input  wire logic       clk,
    input  wire logic [8:0] set_level,
    output logic [8:0]      pins
);
    // Contacts move just after an edge, never while sampled.
    initial pins = 9'h000;
    always @(posedge clk) begin
        pins <= set_level;
    end
endmodule // field_contacts
`default_nettype wire

// >>> tb/itc_asserts.sv
// Port checker of the input terminal conditioner and its bind.
`timescale 1ns/10ps
`default_nettype none
module itc_asserts
    import itc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        fast_pulse_input,
    input wire logic        fast_pulse_level,
    input wire term_vec_t   terminal_state,
    input wire cmd_s        terminal_commands,
    input wire ctrl_mode_e  terminal_control_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_wait_one_low: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("wait low too long");
    a_req_answered: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
        else $error("no answer");
    a_answer_asked: assert property (!avs_waitrequest |-> avs_read || avs_write)
        else $error("stray answer");
    a_rdata_held: assert property ($changed(avs_readdata) |-> $past(avs_read) || $past(avs_read, 2))
        else $error("read data moved");
    a_mode_by_write: assert property ($changed(terminal_control_mode) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("mode moved");
    a_pulse_copy: assert property (fast_pulse_level |-> $past(fast_pulse_input))
        else $error("pulse level without pin");
    a_cmd_from_term: assert property (terminal_commands != '0 |-> $past(terminal_state) != '0)
        else $error("command without terminal");
    // A command moves only after a terminal move or a write.
    a_cmd_cause: assert property ($changed(terminal_commands) |-> $past(terminal_state) !=
        $past(terminal_state, 2) || $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("command moved");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_jog: cover property (terminal_commands.jog_fwd);
    c_comm: cover property (terminal_commands.chan_comm);
endmodule // itc_asserts
bind input_terminal_conditioner itc_asserts u_itc_asserts (.*);
`default_nettype wire

// >>> tb/test_input_terminal_conditioner.sv
// Self-checking bench of the input terminal conditioner.
`timescale 1ns/10ps
`default_nettype none
module test_input_terminal_conditioner
    import itc_pkg::*;
;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest, fast_pulse_level;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [8:0]  lvl, pins;
    term_vec_t   terminal_state;
    cmd_s        terminal_commands;
    ctrl_mode_e  terminal_control_mode;
    int          fail_count, n_checks;
    // Address, write data, expected read-back.
    logic [79:0] rows [8] = '{{16'h8048, 32'h0000_03FF, 32'h0000_01FF},
        {16'h8044, 32'h0000_FFFF, 32'h0000_03E8}, {16'h8054, 32'h0000_FFFF, 32'h0000_C350},
        {16'h8058, 32'h0000_0005, 32'h0000_0005}, {16'h804C, 32'h0000_0007, 32'h0000_0003},
        {16'h8080, 32'h0000_0060, 32'h0000_0001}, {16'h8000, 32'h0000_1234, 32'h0000_0000},
        {16'h8028, 32'h0001_ABCD, 32'h0000_ABCD}};
    logic [47:0] defs [5] = '{{16'h8044, 32'h0000_000A}, {16'h8048, 32'h0000_0000},
        {16'h804C, 32'h0000_0000}, {16'h8084, 32'h0000_0004}, {16'h8088, 32'h0000_0007}};
    logic [18:0] codes [10] = '{{7'h24, 12'h080}, {7'h25, 12'h040}, {7'h26, 12'h020},
        {7'h27, 12'h010}, {7'h28, 12'h008}, {7'h29, 12'h004}, {7'h2A, 12'h002},
        {7'h3D, 12'h001}, {7'h2B, 12'h000}, {7'h5F, 12'h000}};

    input_terminal_conditioner #(.TICK_CYCLES(4)) u_input_terminal_conditioner (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .switch_input_one(pins[0]), .switch_input_two(pins[1]), .switch_input_three(pins[2]),
        .switch_input_four(pins[3]), .switch_input_five(pins[4]), .switch_input_six(pins[5]),
        .switch_input_seven(pins[6]), .switch_input_eight(pins[7]), .fast_pulse_input(pins[8]),
        .terminal_state(terminal_state), .terminal_commands(terminal_commands),
        .terminal_control_mode(terminal_control_mode), .fast_pulse_level(fast_pulse_level));
    field_contacts u_field_contacts (.clk(clk), .set_level(lvl), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic st(input logic [8:0] e);
        chk({23'h0, e}, {23'h0, terminal_state});
    endtask
    task automatic cm(input logic [11:0] e);
        chk({20'h0, e}, {20'h0, terminal_commands});
    endtask
    task automatic hold(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // The request stands until waitrequest is seen low; one idle edge keeps strobes apart.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        if (n >= 40) begin
            fail_count++;
            summarize();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 16'h0000;
        avs_writedata = 32'h0000_0000;
        lvl = 9'h000;
        fail_count = 0;
        n_checks = 0;
        hold(4);
        rst <= 1'b0;
        hold(1);
        foreach (rows[i]) begin
            bus(1'b1, rows[i][79:64], rows[i][63:32]);
            bus(1'b0, rows[i][79:64], 32'h0000_0000);
            chk(rows[i][31:0], q);
        end
        chk(32'h0000_0003, {30'h0, terminal_control_mode});
        rst <= 1'b1;
        hold(1);
        rst <= 1'b0;
        hold(1);
        foreach (defs[i]) begin
            bus(1'b0, defs[i][47:32], 32'h0000_0000);
            chk(defs[i][31:0], q);
        end
        lvl <= 9'h010;
        hold(20);
        st(9'h000);
        hold(40);
        st(9'h010);
        lvl <= 9'h000;
        bus(1'b1, 16'h8044, 32'h0000_0000);
        bus(1'b1, 16'h8040, 32'h0000_0001);
        hold(10);
        st(9'h001);
        cm(12'h800);
        bus(1'b1, 16'h8054, 32'h0000_0003);
        bus(1'b1, 16'h8058, 32'h0000_0005);
        lvl <= 9'h001;
        hold(8);
        st(9'h001);
        hold(40);
        st(9'h000);
        lvl <= 9'h000;
        hold(6);
        st(9'h000);
        hold(30);
        st(9'h001);
        bus(1'b1, 16'h8048, 32'h0000_0002);
        bus(1'b1, 16'h8028, 32'h0000_0002);
        hold(6);
        st(9'h003);
        cm(12'h900);
        bus(1'b1, 16'h8048, 32'h0000_01FF);
        bus(1'b1, 16'h8028, 32'h0000_0020);
        foreach (codes[i]) begin
            bus(1'b1, 16'h8094, {25'h0, codes[i][18:12]});
            hold(4);
            cm(codes[i][11:0]);
        end
        bus(1'b1, 16'h8048, 32'h0000_0000);
        lvl <= 9'h100;
        hold(10);
        chk(32'h0000_0001, {31'h0, fast_pulse_level});
        chk(32'h0000_0000, {31'h0, terminal_state[8]});
        bus(1'b1, 16'h8050, 32'h0000_0001);
        hold(10);
        chk(32'h0000_0001, {31'h0, terminal_state[8]});
        summarize();
    end
endmodule // test_input_terminal_conditioner
`default_nettype wire
